/* File: rtl/i2cbc_pkg.sv */
// constants and types shared by the bus-condition logic
package i2cbc_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHORT_HOLD_NS = 100;
  localparam int LONG_HOLD_NS  = 300;
  localparam int HOLD_W        = 6;
  // least times round up to whole cycles
  localparam logic [HOLD_W-1:0] SHORT_HOLD_CYC =
    HOLD_W'((SHORT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [HOLD_W-1:0] LONG_HOLD_CYC  =
    HOLD_W'((LONG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [HOLD_W-1:0] HOLD_ONE       = 6'h01;

  // ==========================================================================
  // byte framing and addressing
  localparam int          ADDR_W        = 10;
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  ACK_BIT       = 4'h8;
  localparam logic [3:0]  BIT_STEP      = 4'h1;
  localparam logic [4:0]  TEN_BIT_PFX   = 5'h1E;
  localparam logic        PIN_RESET     = 1'h1;

  // ==========================================================================
  // types
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACTIVE} i2cbc_bus_t;

  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR_HI, SL_ADDR_LO, SL_RX, SL_TX, SL_IGNORE
  } i2cbc_phase_t;

  typedef struct packed {
    logic start;
    logic restart;
    logic stop;
    logic collision;
    logic addr_match;
    logic read_req;
  } i2cbc_evt_t;

endpackage : i2cbc_pkg

/* File: rtl/i2cbc_sync.sv */
// three-stage synchroniser with agreement filter for bus pins
`timescale 1ns/1ns
`default_nettype none

module i2cbc_sync #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;

  // ==========================================================================
  // filter: a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
      end
    end
  endgenerate

  // ==========================================================================
  // registers; idle bus lines are high, so reset to one
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_r  <= {W{i2cbc_pkg::PIN_RESET}};
      s2_r  <= {W{i2cbc_pkg::PIN_RESET}};
      s3_r  <= {W{i2cbc_pkg::PIN_RESET}};
      lvl_r <= {W{i2cbc_pkg::PIN_RESET}};
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;

endmodule : i2cbc_sync

`default_nettype wire

/* File: rtl/i2cbc_core.sv */
// two-wire bus-condition front end: pins, hold time, conditions, slave
// Function
// - enabled two-wire mode makes both pins open-drain
// - pin output data fixed at zero
// - long-hold select gives 300 ns hold
// - Start: data falls, clock high
// - own Start collides if data already low
// - Stop: data rises, clock high
// - Stop needs a clock-low period after Start
// - Restart valid wherever Stop valid
// - Restart resets slave like Start
// - 10-bit read after Restart: hold clock
// - prior-match flag set and cleared on events
// - collision when driving high, sampled low
// - idle only with no master, lines high
// - address matches only equal to address register
// - read request: transmit until NACK, collision, Restart or Stop
// - slave data changes while clock low only; own Start and master_release move data with clock high
`timescale 1ns/1ns
`default_nettype none

module i2cbc_core (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        port_enable_bit,
  input  wire logic                        i2c_mode,
  input  wire logic                        long_hold_select,
  input  wire logic                        ten_bit_mode,
  input  wire logic [i2cbc_pkg::ADDR_W-1:0] slave_address_reg,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  input  wire logic                        start_req,
  input  wire logic                        master_release,
  input  wire logic                        tx_data_ready,
  input  wire logic [7:0]                  tx_byte,
  output var  logic                        scl_out,
  output var  logic                        scl_oe,
  output var  logic                        sda_out,
  output var  logic                        sda_oe,
  output var  logic                        bus_idle,
  output var  logic                        prior_match,
  output var  logic                        slave_transmit,
  output var  i2cbc_pkg::i2cbc_evt_t       events
);

  logic                    scl_s;
  logic                    sda_s;
  logic                    en;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    is_start;
  logic                    is_restart;
  logic                    is_stop;
  logic [7:0]              rx_byte;
  logic [i2cbc_pkg::HOLD_W-1:0] hold_cyc;

  logic                    scl_p_r,    sda_p_r;
  logic                    low_seen_r, low_seen_nxt;
  logic                    idle_r,     idle_nxt;
  i2cbc_pkg::i2cbc_bus_t   bus_r,      bus_nxt;
  i2cbc_pkg::i2cbc_phase_t phase_r,    phase_nxt;
  logic [6:0]              shreg_r,    shreg_nxt;
  logic [3:0]              bit_r,      bit_nxt;
  logic [7:0]              txsh_r,     txsh_nxt;
  logic                    prior_r,    prior_nxt;
  logic                    hpend_r,    hpend_nxt;
  logic                    shold_r,    shold_nxt;
  logic                    sdlow_r,    sdlow_nxt;
  logic                    mslow_r,    mslow_nxt;
  logic [i2cbc_pkg::HOLD_W-1:0] hcnt_r, hcnt_nxt;
  logic                    apply_r,    apply_nxt;
  logic                    sdoe_r,     sdoe_nxt;
  logic                    scoe_r,     scoe_nxt;
  logic                    stx_r,      stx_nxt;
  i2cbc_pkg::i2cbc_evt_t   evt_r,      evt_nxt;

  // ==========================================================================
  // pin synchronisers
  i2cbc_sync #(.W(2)) u_sync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pin_in    ({scl_in, sda_in}),
    .level_out ({scl_s, sda_s})
  );

  // ==========================================================================
  // bus conditions
  always_comb begin
    en         = port_enable_bit & i2c_mode;
    scl_rise   = scl_s & ~scl_p_r;
    scl_fall   = ~scl_s & scl_p_r;
    // a clock-low period must separate Start from Stop or Restart
    is_restart = en & scl_s & scl_p_r & sda_p_r & ~sda_s
                 & (bus_r == i2cbc_pkg::BUS_ACTIVE) & low_seen_r;
    is_start   = en & scl_s & scl_p_r & sda_p_r & ~sda_s
                 & ~is_restart;
    is_stop    = en & scl_s & scl_p_r & ~sda_p_r & sda_s
                 & low_seen_r;
    low_seen_nxt = low_seen_r;
    bus_nxt      = bus_r;
    if (!en || is_stop) begin
      bus_nxt      = i2cbc_pkg::BUS_IDLE;
      low_seen_nxt = 1'b0;
    end else if (is_start || is_restart) begin
      bus_nxt      = i2cbc_pkg::BUS_ACTIVE;
      low_seen_nxt = 1'b0;
    end else if (!scl_s && bus_r == i2cbc_pkg::BUS_ACTIVE) begin
      low_seen_nxt = 1'b1;
    end
    idle_nxt = (bus_nxt == i2cbc_pkg::BUS_IDLE) & scl_s & sda_s;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_p_r    <= i2cbc_pkg::PIN_RESET;
      sda_p_r    <= i2cbc_pkg::PIN_RESET;
      low_seen_r <= 1'b0;
      bus_r      <= i2cbc_pkg::BUS_IDLE;
      idle_r     <= 1'b0;
    end else begin
      scl_p_r    <= scl_s;
      sda_p_r    <= sda_s;
      low_seen_r <= low_seen_nxt;
      bus_r      <= bus_nxt;
      idle_r     <= idle_nxt;
    end
  end

  // ==========================================================================
  // slave sequencing, hold timer and pin drive
  always_comb begin
    rx_byte   = {shreg_r, sda_s};
    hold_cyc  = long_hold_select ? i2cbc_pkg::LONG_HOLD_CYC
                                 : i2cbc_pkg::SHORT_HOLD_CYC;
    phase_nxt = phase_r;
    shreg_nxt = shreg_r;
    bit_nxt   = bit_r;
    txsh_nxt  = txsh_r;
    prior_nxt = prior_r;
    hpend_nxt = hpend_r;
    shold_nxt = shold_r;
    sdlow_nxt = sdlow_r;
    mslow_nxt = mslow_r;
    hcnt_nxt  = hcnt_r;
    apply_nxt = apply_r;
    evt_nxt         = '0;
    evt_nxt.start   = is_start;
    evt_nxt.restart = is_restart;
    evt_nxt.stop    = is_stop;
    if (start_req && en) begin
      if (!sda_s) begin
        evt_nxt.collision = 1'b1;
      end else if (idle_r) begin
        mslow_nxt = 1'b1;
      end
    end
    if (master_release) begin
      mslow_nxt = 1'b0;
    end
    if (!en || is_stop) begin
      phase_nxt = i2cbc_pkg::SL_IDLE;
      prior_nxt = prior_r & en & ~is_stop;
      bit_nxt   = 4'h0;
      hpend_nxt = 1'b0;
      shold_nxt = 1'b0;
      sdlow_nxt = 1'b0;
      apply_nxt = 1'b0;
      mslow_nxt = mslow_nxt & en;
    end else if (is_start || is_restart) begin
      phase_nxt = i2cbc_pkg::SL_ADDR_HI;
      bit_nxt   = 4'h0;
      hpend_nxt = 1'b0;
      shold_nxt = 1'b0;
      sdlow_nxt = 1'b0;
      apply_nxt = 1'b0;
    end else begin
      if (scl_rise) begin
        if (phase_r == i2cbc_pkg::SL_TX && bit_r < i2cbc_pkg::ACK_BIT &&
            txsh_r[7] && !sda_s) begin
          evt_nxt.collision = 1'b1;
          phase_nxt = i2cbc_pkg::SL_IGNORE;
          sdlow_nxt = 1'b0;
          apply_nxt = 1'b0;
        end else if (bit_r == i2cbc_pkg::ACK_BIT) begin
          bit_nxt = 4'h0;
          // the address byte's own ack slot is not the master's answer
          if (phase_r == i2cbc_pkg::SL_TX && !hpend_r) begin
            // master NACK ends the read; ACK asks for the next byte
            if (sda_s) begin
              phase_nxt = i2cbc_pkg::SL_IGNORE;
            end else begin
              hpend_nxt = 1'b1;
            end
          end
        end else begin
          bit_nxt   = bit_r + i2cbc_pkg::BIT_STEP;
          shreg_nxt = rx_byte[6:0];
          txsh_nxt  = {txsh_r[6:0], 1'b1};
          if (bit_r == i2cbc_pkg::LAST_DATA_BIT) begin
            unique case (phase_r)
              i2cbc_pkg::SL_ADDR_HI: begin
                if (ten_bit_mode) begin
                  if (rx_byte[7:1] == {i2cbc_pkg::TEN_BIT_PFX,
                                       slave_address_reg[9:8]}) begin
                    if (!rx_byte[0]) begin
                      prior_nxt = 1'b0;
                      phase_nxt = i2cbc_pkg::SL_ADDR_LO;
                    end else if (prior_r) begin
                      phase_nxt          = i2cbc_pkg::SL_TX;
                      hpend_nxt          = 1'b1;
                      evt_nxt.addr_match = 1'b1;
                      evt_nxt.read_req   = 1'b1;
                    end else begin
                      phase_nxt = i2cbc_pkg::SL_IGNORE;
                    end
                  end else begin
                    prior_nxt = 1'b0;
                    phase_nxt = i2cbc_pkg::SL_IGNORE;
                  end
                end else if (rx_byte[7:1] == slave_address_reg[6:0]) begin
                  evt_nxt.addr_match = 1'b1;
                  evt_nxt.read_req   = rx_byte[0];
                  hpend_nxt          = rx_byte[0];
                  phase_nxt = rx_byte[0] ? i2cbc_pkg::SL_TX
                                         : i2cbc_pkg::SL_RX;
                end else begin
                  phase_nxt = i2cbc_pkg::SL_IGNORE;
                end
              end
              i2cbc_pkg::SL_ADDR_LO: begin
                if (rx_byte == slave_address_reg[7:0]) begin
                  prior_nxt          = 1'b1;
                  evt_nxt.addr_match = 1'b1;
                  phase_nxt          = i2cbc_pkg::SL_RX;
                end else begin
                  phase_nxt = i2cbc_pkg::SL_IGNORE;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      if (scl_fall) begin
        if (hpend_r && bit_r == 4'h0) begin
          shold_nxt = 1'b1;
          hpend_nxt = 1'b0;
        end
        hcnt_nxt  = hold_cyc;
        apply_nxt = 1'b1;
      end else if (apply_r) begin
        hcnt_nxt = hcnt_r - i2cbc_pkg::HOLD_ONE;
        if (hcnt_r == i2cbc_pkg::HOLD_ONE) begin
          apply_nxt = 1'b0;
          // a late bit is dropped rather than moved while the clock is high
          if (!scl_s) begin
            sdlow_nxt = (phase_r == i2cbc_pkg::SL_TX) &&
                        (bit_r < i2cbc_pkg::ACK_BIT) && !txsh_r[7];
          end
        end
      end
      if (tx_data_ready && shold_r) begin
        txsh_nxt  = tx_byte;
        shold_nxt = 1'b0;
        hcnt_nxt  = hold_cyc;
        apply_nxt = 1'b1;
      end
    end
    sdoe_nxt = en & (sdlow_nxt | mslow_nxt);
    scoe_nxt = en & shold_nxt;
    stx_nxt  = (phase_nxt == i2cbc_pkg::SL_TX);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_r <= i2cbc_pkg::SL_IDLE;
      shreg_r <= 7'h00;
      bit_r   <= 4'h0;
      txsh_r  <= 8'hFF;
      prior_r <= 1'b0;
      hpend_r <= 1'b0;
      shold_r <= 1'b0;
      sdlow_r <= 1'b0;
      mslow_r <= 1'b0;
      hcnt_r  <= '0;
      apply_r <= 1'b0;
      sdoe_r  <= 1'b0;
      scoe_r  <= 1'b0;
      stx_r   <= 1'b0;
      evt_r   <= '0;
    end else begin
      phase_r <= phase_nxt;
      shreg_r <= shreg_nxt;
      bit_r   <= bit_nxt;
      txsh_r  <= txsh_nxt;
      prior_r <= prior_nxt;
      hpend_r <= hpend_nxt;
      shold_r <= shold_nxt;
      sdlow_r <= sdlow_nxt;
      mslow_r <= mslow_nxt;
      hcnt_r  <= hcnt_nxt;
      apply_r <= apply_nxt;
      sdoe_r  <= sdoe_nxt;
      scoe_r  <= scoe_nxt;
      stx_r   <= stx_nxt;
      evt_r   <= evt_nxt;
    end
  end

  // pins only ever pull low: data value is a constant zero
  assign sda_out        = 1'b0;
  assign scl_out        = 1'b0;
  assign sda_oe         = sdoe_r;
  assign scl_oe         = scoe_r;
  assign bus_idle       = idle_r;
  assign prior_match    = prior_r;
  assign slave_transmit = stx_r;
  assign events         = evt_r;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  pin_release_a: assert property (!en |=> !sda_oe && !scl_oe)
    else $error("pin driven while port disabled");
  start_seen_a: assert property (is_start |=> events.start)
    else $error("start condition not flagged");
  start_coll_a: assert property (start_req && en && !sda_s
                                 |=> events.collision)
    else $error("start collision missed");
  stop_valid_a: assert property (events.stop |-> $past(low_seen_r))
    else $error("stop flagged without clock low time");
  restart_ok_a: assert property (events.restart
                                 |-> $past(low_seen_r))
    else $error("restart flagged without clock low time");
  restart_rst_a: assert property (events.restart |-> bit_r == 4'h0 &&
                  phase_r == i2cbc_pkg::SL_ADDR_HI)
    else $error("restart did not reset slave");
  prior_stop_a: assert property (events.stop |-> !prior_match)
    else $error("prior match survived stop");
  idle_lines_a: assert property (bus_idle |-> $past(scl_s && sda_s))
    else $error("idle with a line low");
  hold_tx_a: assert property ($rose(scl_oe) |-> slave_transmit)
    else $error("clock held outside transmit");
  sda_change_a: assert property ($rose(sdlow_r) |-> !scl_s)
    else $error("data changed while clock high");

  cov_start_c: cover property (events.start);
  cov_restart_c: cover property (events.restart ##[1:1000] events.read_req);
  cov_coll_c: cover property (events.collision);
  cov_stop_c: cover property (events.addr_match ##[1:1000] events.stop);

endmodule : i2cbc_core

`default_nettype wire

/* File: tb/i2cbc_master_model.sv */
// behavioural two-wire bus master facing the bus-condition logic
`timescale 1ns/1ns
`default_nettype none

module i2cbc_master_model #(
  parameter int Q = 25
) (
  input  wire logic ref_clk,
  input  wire logic scl,
  input  wire logic sda,
  output var  logic scl_low,
  output var  logic sda_low
);
  // ==========================================================================
  // line handling
  // a released line reads back through the pull-up in the bench
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt

  // bare data line move, for conditions outside byte framing
  task automatic hold_sda(input logic low);
    sda_low = low;
  endtask : hold_sda

  // slaves may stretch the clock; the wait is bounded so a stuck line
  // cannot hang the run
  task automatic rise;
    int k;
    scl_low = 1'h0;
    for (k = 0; k < 4000 && scl !== 1'h1; k++) @(negedge ref_clk);
  endtask : rise

  // ==========================================================================
  // bit and byte framing
  task automatic bit_x(input logic drv, output logic smp);
    scl_low = 1'h1;
    wt(Q);
    sda_low = ~drv;
    wt(Q);
    rise();
    wt(Q);
    smp = sda;
    wt(Q);
  endtask : bit_x

  task automatic write_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'h1, s);
  endtask : write_byte

  task automatic read_byte(input logic ack, input logic [7:0] pull,
                           output logic [7:0] got);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(~pull[i], got[i]);
    bit_x(ack, s);
  endtask : read_byte

  // ==========================================================================
  // conditions
  task automatic start;
    sda_low = 1'h1;
    wt(2*Q);
  endtask : start

  task automatic stop;
    scl_low = 1'h1;
    wt(Q);
    sda_low = 1'h1;
    wt(Q);
    rise();
    wt(Q);
    sda_low = 1'h0;
    wt(2*Q);
  endtask : stop

  task automatic restart;
    scl_low = 1'h1;
    wt(Q);
    sda_low = 1'h0;
    wt(Q);
    rise();
    wt(Q);
    sda_low = 1'h1;
    wt(2*Q);
  endtask : restart
endmodule : i2cbc_master_model
`default_nettype wire

/* File: tb/i2cbc_core_test.sv */
// self-checking bench for the two-wire bus-condition logic
`timescale 1ns/1ns
`default_nettype none

module i2cbc_core_test;
  // ==========================================================================
  // signals
  localparam int Q = 25;
  localparam int EV_ST = 5, EV_RS = 4, EV_SP = 3;
  localparam int EV_CO = 2, EV_AM = 1, EV_RR = 0;
  logic ref_clk, reset, port_enable_bit, i2c_mode;
  logic long_hold_select, ten_bit_mode, start_req, master_release;
  logic tx_data_ready, scl_out, scl_oe, sda_out, sda_oe;
  logic bus_idle, prior_match, slave_transmit, m_scl_low, m_sda_low;
  logic [i2cbc_pkg::ADDR_W-1:0] slave_address_reg;
  logic [7:0] tx_byte;
  logic [5:0] ev_v;
  i2cbc_pkg::i2cbc_evt_t events;
  wire scl_w, sda_w;
  int n_fail = 0, total_checks = 0, early = 0, bad18 = 0;
  int fall_cnt = 0, hold_c, ev_n[6];
  logic mon_en = 1'h0, prev_oe = 1'h0;

  // open-drain wires with pull-ups
  assign scl_w = (m_scl_low || (scl_oe && !scl_out)) ? 1'h0 : 1'h1;
  assign sda_w = (m_sda_low || (sda_oe && !sda_out)) ? 1'h0 : 1'h1;
  assign ev_v  = events;

  i2cbc_core uut (
    .ref_clk(ref_clk), .reset(reset), .port_enable_bit(port_enable_bit),
    .i2c_mode(i2c_mode), .long_hold_select(long_hold_select),
    .ten_bit_mode(ten_bit_mode), .slave_address_reg(slave_address_reg),
    .scl_in(scl_w), .sda_in(sda_w), .start_req(start_req),
    .master_release(master_release), .tx_data_ready(tx_data_ready),
    .tx_byte(tx_byte), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .bus_idle(bus_idle),
    .prior_match(prior_match), .slave_transmit(slave_transmit),
    .events(events));

  i2cbc_master_model #(.Q(Q)) m (
    .ref_clk(ref_clk), .scl(scl_w), .sda(sda_w),
    .scl_low(m_scl_low), .sda_low(m_sda_low));

  initial ref_clk = 1'h0;
  always #5 ref_clk = ~ref_clk;

  // ==========================================================================
  // monitors: event pulses, and data changes against the clock line
  always @(negedge ref_clk) begin
    for (int i = 0; i < 6; i++) if (ev_v[i] === 1'h1) ev_n[i]++;
    hold_c = long_hold_select ? int'(i2cbc_pkg::LONG_HOLD_CYC)
                              : int'(i2cbc_pkg::SHORT_HOLD_CYC);
    if (mon_en && sda_oe !== prev_oe) begin
      if (scl_w === 1'h1) bad18++;
      else if (fall_cnt < hold_c) early++;
    end
    prev_oe = sda_oe;
    fall_cnt = (scl_w === 1'h0) ? fall_cnt + 1 : 0;
  end

  // ==========================================================================
  // compare and helper tasks
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic clr_ev;
    foreach (ev_n[i]) ev_n[i] = 0;
  endtask : clr_ev

  // slave read: supply the byte once the slave holds the clock
  task automatic rd(input logic [7:0] tx, input logic ack,
                    input logic [7:0] pull, output logic [7:0] got);
    int k;
    fork
      m.read_byte(ack, pull, got);
      begin
        for (k = 0; k < 200 && scl_oe !== 1'h1; k++) @(negedge ref_clk);
        chk_bit(scl_oe, 1'h1);
        tx_byte = tx;
        tx_data_ready = 1'h1;
        @(negedge ref_clk);
        tx_data_ready = 1'h0;
      end
    join
  endtask : rd

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // the tests need about 21k cycles; this leaves ample margin
  initial begin
    repeat (95000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end

  // ==========================================================================
  // tests
  initial begin : main
    logic [7:0] got;
    int h;
    reset = 1'h1;
    port_enable_bit = 1'h1;
    i2c_mode = 1'h1;
    long_hold_select = 1'h0;
    ten_bit_mode = 1'h0;
    slave_address_reg = 10'h02C;
    start_req = 1'h0;
    master_release = 1'h0;
    tx_data_ready = 1'h0;
    tx_byte = 8'h00;
    clr_ev();
    repeat (5) @(negedge ref_clk);
    chk_bit(sda_oe, 1'h0);
    reset = 1'h0;
    for (h = 0; h < 20 && bus_idle !== 1'h1; h++) @(negedge ref_clk);
    chk_bit(bus_idle, 1'h1);
    chk_bit(scl_out, 1'h0);
    chk_bit(sda_out, 1'h0);
    chk_bit(scl_oe, 1'h0);
    $display("test reset done");

    m.start();
    chk_cnt(ev_n[EV_ST], 1);
    chk_bit(bus_idle, 1'h0);
    m.hold_sda(1'h0);
    m.wt(2*Q);
    chk_cnt(ev_n[EV_SP], 0);
    m.stop();
    chk_cnt(ev_n[EV_SP], 1);
    chk_bit(bus_idle, 1'h1);
    $display("test conditions done");

    clr_ev();
    start_req = 1'h1;
    @(negedge ref_clk);
    start_req = 1'h0;
    m.wt(2);
    chk_bit(sda_oe, 1'h1);
    m.wt(2*Q);
    chk_cnt(ev_n[EV_ST], 1);
    chk_cnt(ev_n[EV_CO], 0);
    master_release = 1'h1;
    @(negedge ref_clk);
    master_release = 1'h0;
    m.wt(2*Q);
    chk_bit(sda_oe, 1'h0);
    chk_cnt(ev_n[EV_SP], 0);
    m.stop();
    m.hold_sda(1'h1);
    m.wt(6);
    start_req = 1'h1;
    @(negedge ref_clk);
    start_req = 1'h0;
    m.wt(4);
    chk_cnt(ev_n[EV_CO], 1);
    chk_bit(sda_oe, 1'h0);
    m.stop();
    $display("test own start done");

    for (h = 0; h < 2; h++) begin
      long_hold_select = h[0];
      clr_ev();
      early = 0;
      bad18 = 0;
      m.start();
      m.write_byte({7'h2C, 1'h1});
      chk_cnt(ev_n[EV_AM], 1);
      chk_cnt(ev_n[EV_RR], 1);
      chk_bit(slave_transmit, 1'h1);
      mon_en = 1'h1;
      rd(8'h5A, 1'h0, 8'h00, got);
      chk_byte(got, 8'h5A);
      rd(8'hC3, 1'h1, 8'h00, got);
      chk_byte(got, 8'hC3);
      mon_en = 1'h0;
      chk_cnt(early, 0);
      chk_cnt(bad18, 0);
      m.stop();
      chk_bit(slave_transmit, 1'h0);
    end
    clr_ev();
    m.start();
    m.write_byte({7'h2D, 1'h1});
    chk_cnt(ev_n[EV_AM], 0);
    chk_bit(slave_transmit, 1'h0);
    m.stop();
    $display("test seven bit read done");

    ten_bit_mode = 1'h1;
    slave_address_reg = 10'h2B7;
    clr_ev();
    m.start();
    m.write_byte(8'hF4);
    m.write_byte(8'hB7);
    chk_bit(prior_match, 1'h1);
    m.restart();
    chk_cnt(ev_n[EV_RS], 1);
    m.write_byte(8'hF5);
    chk_cnt(ev_n[EV_RR], 1);
    chk_bit(slave_transmit, 1'h1);
    rd(8'hA5, 1'h1, 8'h80, got);
    chk_cnt(ev_n[EV_CO], 1);
    m.stop();
    chk_bit(prior_match, 1'h0);
    for (h = 0; h < 2; h++) begin
      m.start();
      m.write_byte(8'hF4);
      m.write_byte(8'hB7);
      chk_bit(prior_match, 1'h1);
      m.restart();
      m.write_byte(h == 0 ? 8'hF4 : 8'hF6);
      chk_bit(prior_match, 1'h0);
      m.stop();
    end
    $display("test ten bit done");

    // dropping either enable input must release pins and forget the match
    clr_ev();
    for (h = 1; h < 3; h++) begin
      m.start();
      m.write_byte(8'hF4);
      m.write_byte(8'hB7);
      chk_bit(prior_match, 1'h1);
      port_enable_bit = (h != 1);
      i2c_mode = (h != 2);
      start_req = !(port_enable_bit && i2c_mode);
      @(negedge ref_clk);
      start_req = 1'h0;
      m.wt(4);
      chk_bit(prior_match, 1'h0);
      chk_bit(sda_oe, 1'h0);
      chk_cnt(ev_n[EV_CO], 0);
      port_enable_bit = 1'h1;
      i2c_mode = 1'h1;
      m.stop();
      chk_cnt(ev_n[EV_SP], 0);
    end
    $display("test disable done");
    test_done();
  end
endmodule : i2cbc_core_test
`default_nettype wire
